// ---- rtl/pse_regs.svh ----
// Bit positions, reset values and exception codes of the status word
`ifndef PSE_REGS_SVH
`define PSE_REGS_SVH
// Field positions in the combined status word
`define PSE_ISET_BIT 24
`define PSE_CC_HI_MSB 26
`define PSE_CC_HI_LSB 25
`define PSE_CC_LO_MSB 15
`define PSE_CC_LO_LSB 10
`define PSE_MREG_MSB 15
`define PSE_MREG_LSB 12
`define PSE_NUM_MSB 5
`define PSE_NUM_LSB 0
// Reset values
`define PSE_RST_ISET 1'b1
`define PSE_RST_CC 8'h00
`define PSE_RST_NUM 6'h00
// Exception numbers
`define PSE_EXC_THREAD 6'h00
`define PSE_EXC_NMI 6'h02
`define PSE_EXC_HARD 6'h03
`define PSE_EXC_MEM 6'h04
`define PSE_EXC_BUS 6'h05
`define PSE_EXC_USAGE 6'h06
`define PSE_EXC_SVC 6'h0b
`define PSE_EXC_DEBUG 6'h0c
`define PSE_EXC_PENDED 6'h0e
`define PSE_EXC_TICK 6'h0f
`define PSE_EXC_IRQ0 6'h10
`define PSE_EXC_IRQMAX 6'h2d
`endif

// ---- rtl/pse_pkg.sv ----
// Types shared by the status unit
package pse_pkg;
  // Which view of the status word a read returns
  typedef enum logic [1:0] {
    VIEW_COMBINED,
    VIEW_APP,
    VIEW_EXEC,
    VIEW_INTR
  } pse_view_e;
  // Exception number type
  typedef logic [5:0] pse_excnum_t;
endpackage : pse_pkg

// ---- rtl/pse_status_unit.sv ----
// Execution-state and active-exception fields of the status word
// Function
// - State bit normally stays set
// - Interworking branches and returns may clear it
// - Vector bit zero loads it on entry
// - Executing with state clear raises fault/lockup
// - Reserved bits 23:16, 9:6 read zero
// - Field 15:10 plus 26:25, resets zero
// - Interrupted multiple transfer records next register
// - Return resumes transfer at recorded register
// - Multiple-transfer state keeps bits 11:10 zero
// - Conditional block holds up to four instructions
// - Block conditions same or inverted
// - Bits 5:0 give running exception number
// - System exception numbers fixed encoding
// - Interrupts 0x10 plus n; reserved never shown
// - Fields only meaningful in own views
// - Bits 26:25 zero for multiple-transfer state
`timescale 1ns/10ps
`include "pse_regs.svh"

module pse_status_unit #(
  parameter int NUM_IRQ = 30
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Vector fetch on reset or exception entry
  input wire logic vectorLoad,
  input wire logic [31:0] vectorValue,
  input wire logic excEntry,
  input wire pse_pkg::pse_excnum_t entryNumber,
  // Exception return with stacked status word
  input wire logic excReturn,
  input wire logic [31:0] stackedStatusWord,
  // Interworking branch or stack restore to pc
  input wire logic branchExchange,
  input wire logic targetLsb,
  // Instruction stream
  input wire logic instrIssue,
  input wire logic instrRetire,
  input wire logic multiSuspend,
  input wire logic [3:0] nextRegister,
  input wire logic condBlockPrefix,
  input wire logic [7:0] condBlockBits,
  // Special move access
  input wire logic readReq,
  input wire pse_pkg::pse_view_e readView,
  input wire logic swWrite,
  input wire logic [31:0] swWriteData,
  // State outputs
  output logic compactState,
  output logic [7:0] continuableConditionalState,
  output pse_pkg::pse_excnum_t activeExceptionNumber,
  output logic stateFault,
  output logic lockup,
  output logic resumeMulti,
  output logic [3:0] resumeRegister,
  output logic [31:0] readData,
  output logic readValid
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // True when the number is one the field may report
  function automatic logic isValidNumber(input pse_pkg::pse_excnum_t num);
    logic ok;
    ok = 1'b0;
    case (num)
      `PSE_EXC_THREAD, `PSE_EXC_NMI, `PSE_EXC_HARD, `PSE_EXC_MEM,
      `PSE_EXC_BUS, `PSE_EXC_USAGE, `PSE_EXC_SVC, `PSE_EXC_DEBUG,
      `PSE_EXC_PENDED, `PSE_EXC_TICK: begin
        ok = 1'b1;
      end
      default: begin
        // Interrupt range stops at the last implemented vector
        ok = (num >= `PSE_EXC_IRQ0) && (num <= `PSE_EXC_IRQMAX) &&
          ({26'h0, num - `PSE_EXC_IRQ0} < NUM_IRQ);
      end
    endcase
    return ok;
  endfunction : isValidNumber

  // Field holds a suspended transfer: low four bits zero, register set
  function automatic logic holdsMulti(input logic [7:0] cc);
    return (cc[3:0] == 4'h0) && (cc[7:4] != 4'h0);
  endfunction : holdsMulti

  // Field holds a live conditional block
  function automatic logic holdsBlock(input logic [7:0] cc);
    return cc[3:0] != 4'h0;
  endfunction : holdsBlock

  // ****************************************************************
  // Instruction-set state bit
  // ****************************************************************

  // Sources in priority order; writes never reach it
  // Reset leaves it set so the first fetch is not an instant fault
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      compactState <= `PSE_RST_ISET;
    end else if (vectorLoad) begin
      // Vector bit zero wins over everything else in the same cycle
      compactState <= vectorValue[0];
    end else if (excReturn) begin
      // Restored from the stacked word, may clear it
      compactState <= stackedStatusWord[`PSE_ISET_BIT];
    end else if (branchExchange) begin
      // Target address bit zero selects the new state
      compactState <= targetLsb;
    end
  end

  // Execution attempt with state clear: fault, plus lockup if already
  // in a handler that cannot itself take a fault
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stateFault <= 1'b0;
      lockup <= 1'b0;
    end else begin
      stateFault <= instrIssue && !compactState;
      // Set before clear: a fault in the same cycle as a vector fetch
      // must not be lost
      if (instrIssue && !compactState &&
          (activeExceptionNumber == `PSE_EXC_NMI ||
           activeExceptionNumber == `PSE_EXC_HARD)) begin
        lockup <= 1'b1;
      end else if (vectorLoad) begin
        lockup <= 1'b0; // Only a fresh vector fetch leaves lockup
      end
    end
  end

  // ****************************************************************
  // Continuation / conditional-block field
  // ****************************************************************

  // Layout: [7:2] maps to word bits 15:10, [1:0] to word bits 26:25
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      continuableConditionalState <= `PSE_RST_CC;
    end else if (vectorLoad || excEntry) begin
      // Entry stacks the field, handler starts clean
      continuableConditionalState <= 8'h00;
    end else if (excReturn) begin
      if (holdsMulti({stackedStatusWord[15:10], stackedStatusWord[26:25]})) begin
        // Transfer resumes now, so the field is consumed
        continuableConditionalState <= 8'h00;
      end else begin
        continuableConditionalState <= {stackedStatusWord[`PSE_CC_LO_MSB:`PSE_CC_LO_LSB],
          stackedStatusWord[`PSE_CC_HI_MSB:`PSE_CC_HI_LSB]};
      end
    end else if (multiSuspend) begin
      // Low bits forced zero marks multiple-transfer state
      continuableConditionalState <= {nextRegister, 4'h0};
    end else if (condBlockPrefix) begin
      continuableConditionalState <= condBlockBits;
    end else if (instrRetire && holdsBlock(continuableConditionalState)) begin
      // Shifting the mask moves the next then/else bit into the
      // condition low bit, giving same or inverted condition
      if (continuableConditionalState[2:0] == 3'h0) begin
        continuableConditionalState <= 8'h00;
      end else begin
        continuableConditionalState[4:0] <=
          {continuableConditionalState[3:0], 1'b0};
      end
    end
  end

  // Resume request towards the load/store unit after return
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      resumeMulti <= 1'b0;
      resumeRegister <= 4'h0;
    end else begin
      resumeMulti <= excReturn && !vectorLoad &&
        holdsMulti({stackedStatusWord[15:10], stackedStatusWord[26:25]});
      if (excReturn) begin
        resumeRegister <= stackedStatusWord[`PSE_MREG_MSB:`PSE_MREG_LSB];
      end
    end
  end

  // ****************************************************************
  // Active exception number
  // ****************************************************************

  // Reserved codes are refused, the field keeps its value
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      activeExceptionNumber <= `PSE_RST_NUM;
    end else if (excEntry && isValidNumber(entryNumber)) begin
      activeExceptionNumber <= entryNumber;
    end else if (excReturn && !vectorLoad &&
        isValidNumber(stackedStatusWord[`PSE_NUM_MSB:`PSE_NUM_LSB])) begin
      activeExceptionNumber <= stackedStatusWord[`PSE_NUM_MSB:`PSE_NUM_LSB];
    end
  end

  // ****************************************************************
  // Software read views
  // ****************************************************************

  // Each view shows only its own fields; flags live elsewhere and the
  // write data is deliberately unused because every field is read-only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      readData <= 32'h0;
      readValid <= 1'b0;
    end else begin
      readValid <= readReq;
      if (readReq) begin
        readData <= 32'h0;
        if (readView == pse_pkg::VIEW_COMBINED || readView == pse_pkg::VIEW_EXEC) begin
          readData[`PSE_ISET_BIT] <= compactState;
          readData[`PSE_CC_HI_MSB:`PSE_CC_HI_LSB] <= continuableConditionalState[1:0];
          readData[`PSE_CC_LO_MSB:`PSE_CC_LO_LSB] <= continuableConditionalState[7:2];
        end
        if (readView == pse_pkg::VIEW_COMBINED || readView == pse_pkg::VIEW_INTR) begin
          readData[`PSE_NUM_MSB:`PSE_NUM_LSB] <= activeExceptionNumber;
        end
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  // Retirements seen inside the current block
  logic [2:0] blockCount;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      blockCount <= 3'h0;
    end else if (condBlockPrefix || !holdsBlock(continuableConditionalState)) begin
      blockCount <= 3'h0;
    end else if (instrRetire && blockCount != 3'h7) begin
      blockCount <= blockCount + 3'h1;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_fault_on_clear: assert property (instrIssue && !compactState |=> stateFault)
    else $error("no fault for execution with state bit clear");
  // No spurious fault while the state bit is set
  a_no_false_fault: assert property (!instrIssue || compactState |=> !stateFault)
    else $error("fault raised without cause");
  // A fault inside the fault handlers must end in lockup
  a_lockup_set: assert property (instrIssue && !compactState &&
    (activeExceptionNumber == `PSE_EXC_NMI || activeExceptionNumber == `PSE_EXC_HARD)
    |=> lockup)
    else $error("no lockup for fault inside a fault handler");
  a_vector_bit_load: assert property (vectorLoad |=>
    compactState == $past(vectorValue[0]))
    else $error("state bit not loaded from vector");
  // Return restores the state bit ahead of any branch in the same cycle
  a_return_restore: assert property (excReturn && !vectorLoad |=>
    compactState == $past(stackedStatusWord[`PSE_ISET_BIT]))
    else $error("state bit not restored on return");
  a_branch_clears: assert property (branchExchange && !targetLsb &&
    !vectorLoad && !excReturn |=> !compactState)
    else $error("interworking branch did not clear state bit");
  a_reserved_read_zero: assert property (readValid |->
    readData[23:16] == 8'h00 && readData[9:6] == 4'h0)
    else $error("reserved bits read nonzero");
  // Views that do not own a field show zero there
  a_app_view_blank: assert property (readReq && readView == pse_pkg::VIEW_APP |=>
    readValid && readData == 32'h0)
    else $error("application view returned execution or exception fields");
  a_exec_view_num: assert property (readReq && readView == pse_pkg::VIEW_EXEC |=>
    readValid && readData[5:0] == 6'h00 &&
    readData[`PSE_ISET_BIT] == $past(compactState))
    else $error("execution view returned wrong fields");
  a_multi_record: assert property (multiSuspend && !vectorLoad && !excEntry &&
    !excReturn |=> continuableConditionalState == {$past(nextRegister), 4'h0})
    else $error("suspended register not recorded");
  // Bits 11:10 and 26:25 both sit in the low nibble of the field
  a_multi_low_zero: assert property (multiSuspend && !vectorLoad &&
    !excEntry && !excReturn |=> continuableConditionalState[3:0] == 4'h0)
    else $error("multiple-transfer state with low field bits set");
  a_resume_register: assert property (excReturn && !vectorLoad &&
    stackedStatusWord[11:10] == 2'h0 && stackedStatusWord[26:25] == 2'h0 &&
    stackedStatusWord[15:12] != 4'h0
    |=> resumeMulti && resumeRegister == $past(stackedStatusWord[15:12]))
    else $error("transfer not resumed at recorded register");
  a_block_four_max: assert property (blockCount <= 3'h4)
    else $error("conditional block longer than four");
  a_number_legal: assert property (isValidNumber(activeExceptionNumber))
    else $error("reserved exception number reported");
  // Fault exceptions NMI to usage are taken with their own fixed number
  a_entry_number: assert property (excEntry && entryNumber >= `PSE_EXC_NMI &&
    entryNumber <= `PSE_EXC_USAGE |=> activeExceptionNumber == $past(entryNumber))
    else $error("entered exception number not reported");
  // Reserved codes leave the running number alone
  a_reserved_refused: assert property (excEntry && !excReturn &&
    (entryNumber == 6'h01 || entryNumber == 6'h0d || entryNumber >= 6'h2e ||
    (entryNumber >= 6'h07 && entryNumber <= 6'h0a))
    |=> $stable(activeExceptionNumber))
    else $error("reserved exception number accepted");
  a_write_ignored: assert property (swWrite && !excEntry && !excReturn |=>
    $stable(activeExceptionNumber))
    else $error("software write changed exception number");

endmodule : pse_status_unit

// ---- verification/tb.sv ----
// Self-checking bench for the status unit
`timescale 1ns/10ps
`include "pse_regs.svh"
module tb;
  // ****************
  // Signals
  // ****************
  logic clock = 1'b0, rstn = 1'b0;
  logic vectorLoad = 0, excEntry = 0, excReturn = 0, branchExchange = 0, targetLsb = 0;
  logic instrIssue = 0, instrRetire = 0, multiSuspend = 0, condBlockPrefix = 0;
  logic readReq = 0, swWrite = 0;
  logic [31:0] vectorValue = 0, stackedStatusWord = 0, swWriteData = 0;
  pse_pkg::pse_excnum_t entryNumber = 0;
  logic [3:0] nextRegister = 0;
  logic [7:0] condBlockBits = 0;
  pse_pkg::pse_view_e readView = pse_pkg::VIEW_COMBINED;
  logic compactState, stateFault, lockup, resumeMulti, readValid;
  logic [7:0] continuableConditionalState;
  pse_pkg::pse_excnum_t activeExceptionNumber;
  logic [3:0] resumeRegister;
  logic [31:0] readData;
  int nFail = 0, checksDone = 0, cycles = 0;
  pse_status_unit #(.NUM_IRQ(30)) DUT (.clock(clock), .rstn(rstn),
    .vectorLoad(vectorLoad), .vectorValue(vectorValue), .excEntry(excEntry),
    .entryNumber(entryNumber), .excReturn(excReturn), .stackedStatusWord(stackedStatusWord),
    .branchExchange(branchExchange), .targetLsb(targetLsb), .instrIssue(instrIssue),
    .instrRetire(instrRetire), .multiSuspend(multiSuspend), .nextRegister(nextRegister),
    .condBlockPrefix(condBlockPrefix), .condBlockBits(condBlockBits), .readReq(readReq),
    .readView(readView), .swWrite(swWrite), .swWriteData(swWriteData),
    .compactState(compactState), .continuableConditionalState(continuableConditionalState),
    .activeExceptionNumber(activeExceptionNumber), .stateFault(stateFault), .lockup(lockup),
    .resumeMulti(resumeMulti), .resumeRegister(resumeRegister), .readData(readData),
    .readValid(readValid));
  // 100 ns period core clock
  always #50 clock = ~clock;
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      nFail = nFail + 1;
      complete_run();
    end
  end
  // ****************
  // Helpers
  // ****************
  // Inputs move 1 ns after the edge so sampling never races
  task tick;
    @(posedge clock);
    #1;
  endtask : tick
  task check(input logic [31:0] got, input logic [31:0] exp);
    checksDone = checksDone + 1;
    if (got !== exp) begin
      nFail = nFail + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One read: readValid and data show one cycle after the request;
  // an idle edge follows so back-to-back reads stay separate pulses
  task rd(input pse_pkg::pse_view_e v, input logic [31:0] exp);
    readReq = 1;
    readView = v;
    tick;
    readReq = 0;
    check(readValid, 1);
    check(readData, exp);
    tick;
    check(readValid, 0);
  endtask : rd
  task enter(input logic [5:0] n);
    excEntry = 1;
    entryNumber = n;
    tick;
    excEntry = 0;
    tick;
  endtask : enter
  // ****************
  // Scenarios
  // ****************
  task t_reset;
    rd(pse_pkg::VIEW_COMBINED, 32'h0100_0000);
    rd(pse_pkg::VIEW_APP, 32'h0000_0000);
    swWrite = 1;
    swWriteData = 32'hffff_ffff;
    tick;
    swWrite = 0;
    rd(pse_pkg::VIEW_COMBINED, 32'h0100_0000);
    $display("test reset and views done");
  endtask : t_reset
  task t_numbers;
    logic [5:0] good [12] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0b, 6'h0c, 6'h0e,
      6'h0f, 6'h10, 6'h11, 6'h2d};
    logic [5:0] bad [6] = '{6'h01, 6'h07, 6'h0a, 6'h0d, 6'h2e, 6'h3f};
    for (int i = 0; i < 12; i++) begin
      enter(good[i]);
      check(activeExceptionNumber, good[i]);
      enter(bad[i % 6]);
      check(activeExceptionNumber, good[i]);
    end
    rd(pse_pkg::VIEW_INTR, 32'h0000_002d);
    $display("test exception numbers done");
  endtask : t_numbers
  task t_state;
    enter(6'h03);
    vectorLoad = 1;
    vectorValue = 32'h0000_1000;
    tick;
    vectorLoad = 0;
    check(compactState, 0);
    instrIssue = 1;
    tick;
    instrIssue = 0;
    check(stateFault, 1);
    tick;
    check(stateFault, 0);
    check(lockup, 1);
    branchExchange = 1;
    targetLsb = 1;
    tick;
    branchExchange = 0;
    check(compactState, 1);
    excReturn = 1;
    stackedStatusWord = 32'h0000_0000;
    tick;
    excReturn = 0;
    check(compactState, 0);
    $display("test state bit done");
  endtask : t_state
  task t_multi;
    enter(6'h10);
    multiSuspend = 1;
    nextRegister = 4'h9;
    tick;
    multiSuspend = 0;
    check(continuableConditionalState, 8'h90);
    rd(pse_pkg::VIEW_EXEC, 32'h0000_9000);
    excReturn = 1;
    stackedStatusWord = 32'h0100_5000;
    tick;
    excReturn = 0;
    check(resumeMulti, 1);
    check(resumeRegister, 4'h5);
    check(continuableConditionalState, 8'h00);
    check(activeExceptionNumber, 6'h00);
    tick;
    check(resumeMulti, 0);
    $display("test multiple transfer done");
  endtask : t_multi
  task t_block;
    logic [7:0] seq [4] = '{8'ha2, 8'ha4, 8'ha8, 8'h00};
    instrRetire = 1;
    tick;
    instrRetire = 0;
    check(continuableConditionalState, 8'h00);
    condBlockPrefix = 1;
    condBlockBits = 8'ha1;
    tick;
    condBlockPrefix = 0;
    check(continuableConditionalState, 8'ha1);
    // Held retire walks the block back to back
    instrRetire = 1;
    for (int i = 0; i < 4; i++) begin
      tick;
      check(continuableConditionalState, seq[i]);
    end
    instrRetire = 0;
    $display("test conditional block done");
  endtask : t_block
  // ****************
  // Main sequence
  // ****************
  task complete_run;
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge clock);
    #1;
    rstn = 1;
    t_reset();
    t_numbers();
    t_state();
    t_multi();
    t_block();
    complete_run();
  end
endmodule : tb
